// file: hdl/cllis_pkg.sv
package cllis_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] CLLIS_OFS_LINK_CONTROL = 8'h44;
  localparam logic [7:0] CLLIS_OFS_LINK_STATUS  = 8'h48;
  // link control fields
  localparam int CLLIS_CTL_STALL_LO = 16;
  localparam int CLLIS_CTL_STALL_HI = 17;
  localparam logic [31:0] CLLIS_CTL_RESET   = 32'h0000_0000;
  localparam logic [31:0] CLLIS_CTL_WR_MASK = 32'h0003_0000;
  // link status fields
  localparam int CLLIS_STS_INIT_LSB = 24;
  localparam int CLLIS_STS_ADAPT_LSB = 0;
  localparam int CLLIS_STS_BASE_LSB  = 8;
  localparam int CLLIS_CRED_W = 8;
  // parameter exchange
  localparam int CLLIS_PARAM_W = 16;
  localparam logic [3:0] CLLIS_ROUTER_VALUE = 4'h1;
  localparam logic [11:0] CLLIS_LOCAL_ID = 12'h05a; // arbitrary value
  localparam int CLLIS_RSVD_W = 4;
  // init state codes
  typedef enum logic [3:0] {
    CLLIS_ST_WAIT_PHY   = 4'h0,
    CLLIS_ST_SW_STALL   = 4'h1,
    CLLIS_ST_PARAM_XCHG = 4'h2,
    CLLIS_ST_DONE       = 4'h3
  } cllis_state_t;
endpackage

// file: hdl/cllis_top.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// R01 - control bits 17 and 16 force init to stall until software clears them
// R02 - status bits 27:24 report the current init state
// R03 - internal-stall code shown only for software-forced stalls
// R04 - waiting-for-phy code shown while waiting phy, including other internal stalls
// R05 - non-zero reserved check field on received packet flags unsupported packet error
// R06 - exchange parameters in hardware, store received ones, use them for link
// R07 - router parameter sent during exchange carries value one
// R08 - status reports transmit-side adaptive and base credit counts
// R09 - init state field is read-only and follows live state
module cllis_top
  import cllis_pkg::*;
(
  input  wire logic                     CLK_SYS,       // 25 MHz core clock
  input  wire logic                     RST_N,         // sync reset, active low
  input  wire logic                     REG_WR,        // register write strobe
  input  wire logic                     REG_RD,        // register read strobe
  input  wire logic [7:0]               REG_ADDR,      // register byte address
  input  wire logic [31:0]              REG_WDATA,     // register write data
  output logic      [31:0]              REG_RDATA,     // register read data
  input  wire logic                     PHY_READY,     // physical layer ready (pin)
  input  wire logic                     INT_STALL,     // other internal stall request
  output logic                          TX_PARAM_VLD,  // local parameter word valid
  output logic      [CLLIS_PARAM_W-1:0] TX_PARAM,      // local parameter word
  input  wire logic                     RX_PARAM_VLD,  // partner parameter valid
  input  wire logic [CLLIS_PARAM_W-1:0] RX_PARAM,      // partner parameter word
  output logic      [CLLIS_PARAM_W-1:0] PEER_PARAM,    // stored partner parameters
  output logic                          LINK_UP,       // init complete
  input  wire logic                     RX_PKT_VLD,    // received packet strobe
  input  wire logic [CLLIS_RSVD_W-1:0]  RX_RESERVED_CHECK_FIELD,   // reserved check field of packet
  output logic                          PKT_ERR,       // unsupported packet error pulse
  input  wire logic                     TX_CRED_RET,   // partner returned one credit
  input  wire logic                     TX_CRED_BASE,  // returned credit is base network
  input  wire logic                     TX_CRED_USE,   // transmitter consumed one credit
  input  wire logic                     TX_USE_BASE    // consumed credit is base network
);

  // two-flop synchronisers for pin inputs
  logic [1:0] phy_sync_q, phy_sync_d;
  always_comb begin
    phy_sync_d = {phy_sync_q[0], PHY_READY};
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) phy_sync_q <= 2'b00;
    else phy_sync_q <= phy_sync_d;
  end
  wire logic phy_ready_s = phy_sync_q[1];

  // control register: only stall bits are writable
  logic [31:0] ctl_q, ctl_d;
  always_comb begin
    ctl_d = ctl_q;
    if (REG_WR && REG_ADDR == CLLIS_OFS_LINK_CONTROL) begin
      ctl_d = REG_WDATA & CLLIS_CTL_WR_MASK; // R01
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) ctl_q <= CLLIS_CTL_RESET;
    else ctl_q <= ctl_d;
  end
  wire logic sw_stall = ctl_q[CLLIS_CTL_STALL_HI] | ctl_q[CLLIS_CTL_STALL_LO]; // R01

  // init state machine
  cllis_state_t st_q, st_d;
  logic [CLLIS_PARAM_W-1:0] peer_q, peer_d;
  logic                     up_q, up_d;
  always_comb begin
    st_d   = st_q;
    peer_d = peer_q;
    up_d   = 1'b0;
    case (st_q)
      CLLIS_ST_WAIT_PHY: begin
        // other internal stalls just hold here, showing the wait code
        if (sw_stall) st_d = CLLIS_ST_SW_STALL; // R03
        else if (phy_ready_s && !INT_STALL) st_d = CLLIS_ST_PARAM_XCHG; // R04
      end
      CLLIS_ST_SW_STALL: begin
        if (!sw_stall) st_d = CLLIS_ST_WAIT_PHY; // R01
      end
      CLLIS_ST_PARAM_XCHG: begin
        // a software stall halts an exchange in progress; a live link is left alone
        if (sw_stall) st_d = CLLIS_ST_SW_STALL; // R01
        else if (!phy_ready_s) st_d = CLLIS_ST_WAIT_PHY;
        else if (RX_PARAM_VLD) begin
          peer_d = RX_PARAM; // R06
          st_d   = CLLIS_ST_DONE;
        end
      end
      CLLIS_ST_DONE: begin
        up_d = phy_ready_s;
        if (!phy_ready_s) st_d = CLLIS_ST_WAIT_PHY;
      end
      default: st_d = CLLIS_ST_WAIT_PHY;
    endcase
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_q   <= CLLIS_ST_WAIT_PHY;
      peer_q <= '0;
      up_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      peer_q <= peer_d;
      up_q   <= up_d;
    end
  end

  // transmit credit counters, partner returns and local use
  function automatic logic [CLLIS_CRED_W-1:0] cred_next(
    input logic [CLLIS_CRED_W-1:0] cnt,
    input logic                    inc,
    input logic                    dec
  );
    logic [CLLIS_CRED_W-1:0] r;
    r = cnt;
    if (inc && !dec && cnt != '1) r = cnt + 1'b1;
    else if (dec && !inc && cnt != '0) r = cnt - 1'b1;
    return r;
  endfunction
  logic [CLLIS_CRED_W-1:0] adapt_q, adapt_d, base_q, base_d;
  logic                    use_ok;
  always_comb begin
    use_ok  = up_q & TX_CRED_USE;
    adapt_d = cred_next(adapt_q, up_q & TX_CRED_RET & ~TX_CRED_BASE,
                        use_ok & ~TX_USE_BASE); // R08
    base_d  = cred_next(base_q, up_q & TX_CRED_RET & TX_CRED_BASE,
                        use_ok & TX_USE_BASE);  // R08
    if (!up_q) begin
      // credits are only meaningful on a live link
      adapt_d = '0;
      base_d  = '0;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      adapt_q <= '0;
      base_q  <= '0;
    end else begin
      adapt_q <= adapt_d;
      base_q  <= base_d;
    end
  end

  // outputs: parameter send, error flag, read data
  logic [31:0]              rdata_q, rdata_d;
  logic                     err_q, err_d, txv_q, txv_d;
  logic [CLLIS_PARAM_W-1:0] txp_q, txp_d;
  logic [31:0]              sts;
  always_comb begin
    sts = '0;
    sts[CLLIS_STS_INIT_LSB +: 4]             = st_q;    // R02 R09
    sts[CLLIS_STS_ADAPT_LSB +: CLLIS_CRED_W] = adapt_q; // R08
    sts[CLLIS_STS_BASE_LSB +: CLLIS_CRED_W]  = base_q;  // R08
    rdata_d = 32'h0000_0000;
    if (REG_RD) begin
      if (REG_ADDR == CLLIS_OFS_LINK_CONTROL) rdata_d = ctl_q;
      else if (REG_ADDR == CLLIS_OFS_LINK_STATUS) rdata_d = sts; // R09
    end
    err_d = RX_PKT_VLD && (RX_RESERVED_CHECK_FIELD != '0); // R05
    txv_d = (st_d == CLLIS_ST_PARAM_XCHG);     // R06
    txp_d = {CLLIS_ROUTER_VALUE, CLLIS_LOCAL_ID}; // R07
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rdata_q <= '0;
      err_q   <= 1'b0;
      txv_q   <= 1'b0;
      txp_q   <= '0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
      txv_q   <= txv_d;
      txp_q   <= txp_d;
    end
  end

  assign REG_RDATA    = rdata_q;
  assign PKT_ERR      = err_q;
  assign TX_PARAM_VLD = txv_q;
  assign TX_PARAM     = txp_q;
  assign PEER_PARAM   = peer_q;
  assign LINK_UP      = up_q;

  // checks
  a_stall_holds: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    sw_stall && st_q != CLLIS_ST_DONE |=> st_q == CLLIS_ST_SW_STALL) // R01
    else $error("init advanced under software stall");
  a_status_field: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    REG_RD && REG_ADDR == CLLIS_OFS_LINK_STATUS |=> REG_RDATA[27:24] == $past(st_q)) // R02
    else $error("status field does not show init state");
  a_stall_code_sw: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    st_q == CLLIS_ST_SW_STALL |-> $past(sw_stall)) // R03
    else $error("stall code without software stall");
  a_wait_code_int: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    st_q == CLLIS_ST_WAIT_PHY && INT_STALL && !sw_stall |=> st_q == CLLIS_ST_WAIT_PHY) // R04
    else $error("internal stall left wait code");
  a_rsvd_error: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    RX_PKT_VLD && RX_RESERVED_CHECK_FIELD != '0 |=> PKT_ERR) // R05
    else $error("reserved check violation not flagged");
  a_peer_stored: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    st_q == CLLIS_ST_PARAM_XCHG && phy_ready_s && RX_PARAM_VLD && !sw_stall
    |=> PEER_PARAM == $past(RX_PARAM) ##1 LINK_UP || !phy_ready_s) // R06
    else $error("partner parameters not stored");
  a_router_one: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    TX_PARAM_VLD |-> TX_PARAM[15:12] == 4'h1) // R07
    else $error("router parameter not one");
  a_credit_tx: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    up_q && TX_CRED_RET && !TX_CRED_BASE && !TX_CRED_USE && adapt_q != 8'hff && up_d
    |=> adapt_q == $past(adapt_q) + 8'h01) // R08
    else $error("adaptive transmit credit not counted");
  a_init_ro: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    REG_WR && REG_ADDR == CLLIS_OFS_LINK_STATUS && st_q == CLLIS_ST_DONE && phy_ready_s
    |=> st_q == CLLIS_ST_DONE) // R09
    else $error("status write disturbed init state");
  c_sw_stall: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    st_q == CLLIS_ST_SW_STALL ##1 st_q == CLLIS_ST_WAIT_PHY);
  c_link_up: cover property (@(posedge CLK_SYS) disable iff (!RST_N) $rose(LINK_UP));
  c_pkt_err: cover property (@(posedge CLK_SYS) disable iff (!RST_N) PKT_ERR);

endmodule
`default_nettype wire

// file: sim/cllis_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-end link agent: answers each parameter exchange with its own word
module cllis_peer_model
  import cllis_pkg::*;
#(
  parameter logic [CLLIS_PARAM_W-1:0] PEER_WORD = 16'h1a33, // arbitrary value
  parameter int                       DELAY     = 3         // cycles before answering
) (
  input  wire logic                     clk,        // core clock
  input  wire logic                     rst_n,      // sync reset, active low
  input  wire logic                     tx_vld,     // local word on offer
  input  wire logic [CLLIS_PARAM_W-1:0] tx_param,   // local word
  output logic                          rx_vld,     // peer word strobe
  output logic      [CLLIS_PARAM_W-1:0] rx_param,   // peer word
  output logic      [CLLIS_PARAM_W-1:0] seen_param  // local word the peer stored
);
  logic                     vld_q  = 1'b0;
  logic [CLLIS_PARAM_W-1:0] word_q = '0;
  logic [CLLIS_PARAM_W-1:0] seen_q = '0;
  logic                     sent_q = 1'b0;
  int                       wait_q = 0;
  assign rx_vld     = vld_q;
  assign rx_param   = word_q;
  assign seen_param = seen_q;
  // one word per exchange; idle line shows the inverse so a stale word never matches
  always @(posedge clk) begin
    vld_q  <= 1'b0;
    word_q <= ~PEER_WORD;
    if (!rst_n || !tx_vld) begin
      sent_q <= 1'b0;
      wait_q <= 0;
    end else if (!sent_q) begin
      seen_q <= tx_param;
      wait_q <= wait_q + 1;
      if (wait_q == DELAY) begin
        vld_q  <= 1'b1;
        word_q <= PEER_WORD;
        sent_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/cllis_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module cllis_test;
  import cllis_pkg::*;
  localparam logic [15:0] WORD = 16'h1a33;
  // reserved check values sent in order: 5, 0, 8, 1 (nibble 0 first)
  localparam logic [15:0] PKTS = 16'h1805;
  logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, phy_ready = 0, int_stall = 0;
  logic        pkt_vld = 0, c_ret = 0, c_base = 0, c_use = 0, u_base = 0;
  logic [3:0]  rsvd = '0;
  logic [7:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, rd_v;
  logic [15:0] tx_param, rx_param, peer_param, seen;
  logic        tx_vld, rx_vld, link_up, pkt_err;
  int          fails = 0, tests_run = 0;
  always #20 clk = ~clk;
  cllis_top dut (.CLK_SYS(clk), .RST_N(rst_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .PHY_READY(phy_ready), .INT_STALL(int_stall), .TX_PARAM_VLD(tx_vld),
    .TX_PARAM(tx_param), .RX_PARAM_VLD(rx_vld), .RX_PARAM(rx_param),
    .PEER_PARAM(peer_param), .LINK_UP(link_up), .RX_PKT_VLD(pkt_vld),
    .RX_RESERVED_CHECK_FIELD(rsvd), .PKT_ERR(pkt_err), .TX_CRED_RET(c_ret), .TX_CRED_BASE(c_base),
    .TX_CRED_USE(c_use), .TX_USE_BASE(u_base));
  cllis_peer_model #(.PEER_WORD(WORD), .DELAY(3)) peer (.clk(clk), .rst_n(rst_n),
    .tx_vld(tx_vld), .tx_param(tx_param), .rx_vld(rx_vld), .rx_param(rx_param),
    .seen_param(seen));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // register write and read: strobe for one edge, data lands the cycle after a read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  // bounded wait on the link level; running out ends the run
  task automatic wait_up(input logic v);
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      #1;
      if (link_up === v) return;
    end
    fails++;
    $display("wrong value link_up exp %h got %h", v, link_up);
    summarize();
  endtask
  task automatic cred(input logic r, input logic rb, input logic u, input logic ub);
    @(posedge clk);
    {c_ret, c_base, c_use, u_base} <= {r, rb, u, ub};
    @(posedge clk);
    {c_ret, c_use} <= 2'b00;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(CLLIS_OFS_LINK_STATUS);
    `CHK("status at reset", 32'h0000_0000, rd_v)
    wr(CLLIS_OFS_LINK_CONTROL, 32'hffff_ffff);
    rd(CLLIS_OFS_LINK_CONTROL);
    `CHK("control", 32'h0003_0000, rd_v)
    rd(8'h4c);
    `CHK("unmapped", 32'h0000_0000, rd_v)
    @(posedge clk);
    phy_ready <= 1'b1;
    repeat (10) @(posedge clk);
    rd(CLLIS_OFS_LINK_STATUS);
    `CHK("stall code", 4'h1, rd_v[27:24])
    wr(CLLIS_OFS_LINK_CONTROL, 32'h0002_0000);
    repeat (6) @(posedge clk);
    rd(CLLIS_OFS_LINK_STATUS);
    `CHK("stall bit17", 4'h1, rd_v[27:24])
    `CHK("link held", 1'b0, link_up)
    $display("test stall done");
    wr(CLLIS_OFS_LINK_CONTROL, 32'h0000_0000);
    wait_up(1'b1);
    `CHK("peer word", WORD, peer_param)
    `CHK("router value", 4'h1, seen[15:12])
    wr(CLLIS_OFS_LINK_STATUS, 32'h0f00_0000);
    rd(CLLIS_OFS_LINK_STATUS);
    `CHK("state read-only", 4'h3, rd_v[27:24])
    $display("test exchange done");
    repeat (3) cred(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (2) cred(1'b1, 1'b1, 1'b0, 1'b0);
    cred(1'b0, 1'b0, 1'b1, 1'b1);
    rd(CLLIS_OFS_LINK_STATUS);
    `CHK("tx credits", 16'h0103, rd_v[15:0])
    $display("test credits done");
    // packet field values: zero must pass, any other flags one error pulse
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pkt_vld <= 1'b1;
      rsvd    <= PKTS[4*i +: 4];
      @(posedge clk);
      pkt_vld <= 1'b0;
      #1 `CHK("pkt err", (i != 1), pkt_err)
    end
    $display("test packets done");
    @(posedge clk);
    int_stall <= 1'b1;
    phy_ready <= 1'b0;
    wait_up(1'b0);
    phy_ready <= 1'b1;
    repeat (8) @(posedge clk);
    rd(CLLIS_OFS_LINK_STATUS);
    `CHK("internal stall code", 4'h0, rd_v[27:24])
    int_stall <= 1'b0;
    wait_up(1'b1);
    `CHK("relink word", WORD, peer_param)
    $display("test internal stall done");
    summarize();
  end
endmodule
`default_nettype wire
